// ===== src/cpu_insn_tail_decode.v
`timescale 1ns/1ps
`include "cpu_insn_tail_decode_defines.vh"
module cpu_insn_tail_decode (
	// Clock and reset.
	input wire clk,
	input wire rst_n,
	// Byte-wide memory bus; read data belongs to the address presented.
	output reg [15:0] mem_addr_r,
	input wire [7:0] mem_rdata,
	output reg mem_we_r,
	output reg [7:0] mem_wdata_r,
	// Interrupt request pin.
	input wire irq_req,
	// Core status.
	output reg halted_r,
	output reg fetch_r,
	output reg [15:0] pc_r,
	output reg [15:0] sp_r,
	output reg [7:0] acc_r,
	output reg [7:0] idx_hi_r,
	output reg [7:0] idx_lo_r,
	output reg [7:0] condition_flags_r
);

	localparam S_FETCH = 4'h0;
	localparam S_PRE = 4'h1;
	localparam S_OP1 = 4'h2;
	localparam S_OP2 = 4'h3;
	localparam S_REL = 4'h4;
	localparam S_MEM = 4'h5;
	localparam S_WR = 4'h6;
	localparam S_TWO = 4'h7;
	localparam S_HALT = 4'h8;
	localparam S_TRAP = 4'h9;

	reg [3:0] state_r, state_nxt;
	reg [2:0] cnt_r, cnt_nxt;
	reg [7:0] op1_r, op1_nxt;
	reg [7:0] rel_r, rel_nxt;
	reg [3:0] cls_r, cls_nxt;
	reg [2:0] mode_r, mode_nxt;
	reg [1:0] nb_r, nb_nxt;
	reg hasrel_r, hasrel_nxt;
	reg post_r, post_nxt;
	reg [1:0] mov_r, mov_nxt;
	reg [15:0] addr_nxt, pc_nxt, sp_nxt;
	reg [7:0] wdata_nxt, acc_nxt, xh_nxt, xl_nxt, flg_nxt;
	reg we_nxt, halted_nxt;
	reg irq_s1_r, irq_s2_r, irq_s3_r, irq_lvl_r;
	reg [3:0] dec_cls;
	reg [2:0] dec_mode;
	reg [1:0] dec_nb;
	reg dec_rel, dec_post;
	reg [1:0] dec_mov;
	reg [2:0] mode_sel;
	reg [7:0] ea_lo;
	wire [15:0] hx;
	wire [15:0] ea;
	wire [15:0] hx_inc;

	assign hx = {idx_hi_r, idx_lo_r};
	assign hx_inc = hx + 16'h0001;

	// Clears overflow, sets negative and zero from a value, keeps the rest.
	function [7:0] nz_flags;
		input [7:0] f;
		input [7:0] v;
		begin
			nz_flags = f;
			nz_flags[`FLG_V] = 1'b0;
			nz_flags[`FLG_N] = v[7];
			nz_flags[`FLG_Z] = (v == 8'h00);
		end
	endfunction

	// Decodes the byte on the bus; the prefix selects the stack forms.
	always @* begin
		dec_cls = `CLS_NOP;
		dec_mode = `MODE_DIR;
		dec_nb = 2'h0;
		dec_rel = 1'b0;
		dec_post = 1'b0;
		dec_mov = `MOV_NONE;
		case ({state_r == S_PRE, mem_rdata})
			{1'b0, `OP_TRAP}: dec_cls = `CLS_TRAP;
			{1'b0, `OP_TAP}: dec_cls = `CLS_TAP;
			{1'b0, `OP_FLAGS_TO_ACC}: dec_cls = `CLS_F2A;
			{1'b0, `OP_WAIT}: dec_cls = `CLS_WAIT;
			{1'b0, `OP_INDEX_TO_STACK}: dec_cls = `CLS_X2S;
			{1'b0, `OP_STACK_TO_INDEX}: dec_cls = `CLS_S2X;
			{1'b0, `OP_ACC_TO_INDEX}: dec_cls = `CLS_A2X;
			{1'b0, `OP_INDEX_TO_ACC}: dec_cls = `CLS_X2A;
			{1'b0, `OP_ZT_A}: dec_cls = `CLS_ZTA;
			{1'b0, `OP_ZT_X}: dec_cls = `CLS_ZTX;
			{1'b0, `OP_ZT_DIR}: begin
				dec_cls = `CLS_ZT;
				dec_nb = 2'h1;
			end
			{1'b0, `OP_ZT_IX1}: begin
				dec_cls = `CLS_ZT;
				dec_mode = `MODE_IX1;
				dec_nb = 2'h1;
			end
			{1'b0, `OP_ZT_IX}: begin
				dec_cls = `CLS_ZT;
				dec_mode = `MODE_IX;
			end
			{1'b1, `OP_ZT_SPS}: begin
				dec_cls = `CLS_ZT;
				dec_mode = `MODE_SPS;
				dec_nb = 2'h1;
			end
			{1'b0, `OP_CBEQ_DIR}: begin
				dec_cls = `CLS_CBEQ;
				dec_nb = 2'h1;
				dec_rel = 1'b1;
			end
			{1'b0, `OP_CBEQ_IX1P}: begin
				dec_cls = `CLS_CBEQ;
				dec_mode = `MODE_IX1;
				dec_nb = 2'h1;
				dec_rel = 1'b1;
				dec_post = 1'b1;
			end
			{1'b0, `OP_CBEQ_IXP}: begin
				dec_cls = `CLS_CBEQ;
				dec_mode = `MODE_IX;
				dec_rel = 1'b1;
				dec_post = 1'b1;
			end
			{1'b1, `OP_CBEQ_SPS}: begin
				dec_cls = `CLS_CBEQ;
				dec_mode = `MODE_SPS;
				dec_nb = 2'h1;
				dec_rel = 1'b1;
			end
			{1'b0, `OP_MOV_DIXP}: begin
				dec_cls = `CLS_MOV;
				dec_nb = 2'h1;
				dec_post = 1'b1;
				dec_mov = `MOV_DIXP;
			end
			{1'b0, `OP_MOV_IMMD}: begin
				dec_cls = `CLS_MOV;
				dec_nb = 2'h2;
				dec_mov = `MOV_IMMD;
			end
			{1'b0, `OP_MOV_IXPD}: begin
				dec_cls = `CLS_MOV;
				dec_mode = `MODE_IX;
				dec_nb = 2'h1;
				dec_post = 1'b1;
				dec_mov = `MOV_IXPD;
			end
			{1'b0, `OP_LDA_FULL}: begin
				dec_cls = `CLS_LDA;
				dec_mode = `MODE_FULL;
				dec_nb = 2'h2;
			end
			{1'b0, `OP_LDA_IXL}: begin
				dec_cls = `CLS_LDA;
				dec_mode = `MODE_IXL;
				dec_nb = 2'h2;
			end
			{1'b1, `OP_LDA_SPL}: begin
				dec_cls = `CLS_LDA;
				dec_mode = `MODE_SPL;
				dec_nb = 2'h2;
			end
			default: dec_cls = `CLS_NOP;
		endcase
	end

	// Address generator inputs: the fresh decode at opcode time.
	always @* begin
		if (state_r == S_FETCH || state_r == S_PRE)
			mode_sel = dec_mode;
		else
			mode_sel = mode_r;
		if (state_r == S_REL)
			ea_lo = op1_r;
		else
			ea_lo = mem_rdata;
	end

	operand_addr_gen u_ea (
		.mode(mode_sel),
		.hx(hx),
		.sp(sp_r),
		.hi(op1_r),
		.lo(ea_lo),
		.ea(ea)
	);

	// Sequencer: one state per bus cycle.
	always @* begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		op1_nxt = op1_r;
		rel_nxt = rel_r;
		cls_nxt = cls_r;
		mode_nxt = mode_r;
		nb_nxt = nb_r;
		hasrel_nxt = hasrel_r;
		post_nxt = post_r;
		mov_nxt = mov_r;
		addr_nxt = pc_r;
		pc_nxt = pc_r;
		sp_nxt = sp_r;
		wdata_nxt = mem_wdata_r;
		we_nxt = 1'b0;
		acc_nxt = acc_r;
		xh_nxt = idx_hi_r;
		xl_nxt = idx_lo_r;
		flg_nxt = condition_flags_r;
		halted_nxt = 1'b0;
		case (state_r)
			S_FETCH, S_PRE: begin
				pc_nxt = pc_r + 16'h0001;
				addr_nxt = pc_nxt;
				cls_nxt = dec_cls;
				mode_nxt = dec_mode;
				nb_nxt = dec_nb;
				hasrel_nxt = dec_rel;
				post_nxt = dec_post;
				mov_nxt = dec_mov;
				if (state_r == S_FETCH && mem_rdata == `OP_PREFIX) begin
					state_nxt = S_PRE;
				end else begin
					state_nxt = S_FETCH;
					case (dec_cls)
						`CLS_A2X: xl_nxt = acc_r;
						`CLS_X2A: acc_nxt = idx_lo_r;
						`CLS_F2A: acc_nxt = condition_flags_r;
						`CLS_TAP: begin
							flg_nxt = acc_r | `FLG_ONES;
							state_nxt = S_TWO;
						end
						`CLS_S2X: begin
							{xh_nxt, xl_nxt} = sp_r + 16'h0001;
							state_nxt = S_TWO;
						end
						`CLS_X2S: begin
							sp_nxt = hx - 16'h0001;
							state_nxt = S_TWO;
						end
						`CLS_ZTA: begin
							flg_nxt = nz_flags(condition_flags_r, acc_r);
						end
						`CLS_ZTX: begin
							flg_nxt = nz_flags(condition_flags_r, idx_lo_r);
						end
						`CLS_WAIT: begin
							flg_nxt[`FLG_I] = 1'b0;
							halted_nxt = 1'b1;
							state_nxt = S_HALT;
						end
						`CLS_TRAP: begin
							// First push is the low byte of the advanced counter.
							addr_nxt = sp_r;
							we_nxt = 1'b1;
							wdata_nxt = pc_nxt[7:0];
							cnt_nxt = 3'h0;
							state_nxt = S_TRAP;
						end
						`CLS_ZT, `CLS_LDA, `CLS_CBEQ, `CLS_MOV: begin
							if (dec_nb != 2'h0) begin
								state_nxt = S_OP1;
							end else if (dec_rel) begin
								state_nxt = S_REL;
							end else begin
								addr_nxt = ea;
								state_nxt = S_MEM;
							end
						end
						default: state_nxt = S_FETCH;
					endcase
				end
			end
			S_OP1: begin
				pc_nxt = pc_r + 16'h0001;
				addr_nxt = pc_nxt;
				op1_nxt = mem_rdata;
				if (nb_r == 2'h2) begin
					state_nxt = S_OP2;
				end else if (hasrel_r) begin
					state_nxt = S_REL;
				end else begin
					addr_nxt = ea;
					state_nxt = S_MEM;
				end
			end
			S_OP2: begin
				pc_nxt = pc_r + 16'h0001;
				addr_nxt = ea;
				if (cls_r == `CLS_MOV) begin
					we_nxt = 1'b1;
					wdata_nxt = op1_r;
					flg_nxt = nz_flags(condition_flags_r, op1_r);
					state_nxt = S_WR;
				end else begin
					state_nxt = S_MEM;
				end
			end
			S_REL: begin
				pc_nxt = pc_r + 16'h0001;
				rel_nxt = mem_rdata;
				addr_nxt = ea;
				state_nxt = S_MEM;
			end
			S_MEM: begin
				state_nxt = S_FETCH;
				if (post_r)
					{xh_nxt, xl_nxt} = hx_inc;
				case (cls_r)
					`CLS_ZT: begin
						flg_nxt = nz_flags(condition_flags_r, mem_rdata);
					end
					`CLS_LDA: begin
						acc_nxt = mem_rdata;
						flg_nxt = nz_flags(condition_flags_r, mem_rdata);
					end
					`CLS_CBEQ: begin
						if (acc_r == mem_rdata)
							pc_nxt = pc_r + {{8{rel_r[7]}}, rel_r};
						addr_nxt = pc_nxt;
					end
					`CLS_MOV: begin
						if (mov_r == `MOV_DIXP)
							addr_nxt = hx;
						else
							addr_nxt = {8'h00, op1_r};
						we_nxt = 1'b1;
						wdata_nxt = mem_rdata;
						flg_nxt = nz_flags(condition_flags_r, mem_rdata);
						state_nxt = S_WR;
					end
					default: state_nxt = S_FETCH;
				endcase
			end
			S_WR: state_nxt = S_FETCH;
			S_TWO: state_nxt = S_FETCH;
			S_HALT: begin
				// Execution stays frozen until a filtered request is seen.
				if (irq_lvl_r) begin
					state_nxt = S_FETCH;
				end else begin
					halted_nxt = 1'b1;
					addr_nxt = mem_addr_r;
				end
			end
			S_TRAP: begin
				cnt_nxt = cnt_r + 3'h1;
				addr_nxt = mem_addr_r;
				case (cnt_r)
					3'h0, 3'h1, 3'h2, 3'h3: begin
						sp_nxt = sp_r - 16'h0001;
						addr_nxt = sp_nxt;
						we_nxt = 1'b1;
						if (cnt_r == 3'h0)
							wdata_nxt = pc_r[15:8];
						else if (cnt_r == 3'h1)
							wdata_nxt = idx_lo_r;
						else if (cnt_r == 3'h2)
							wdata_nxt = acc_r;
						else
							wdata_nxt = condition_flags_r;
					end
					3'h4: begin
						sp_nxt = sp_r - 16'h0001;
						flg_nxt[`FLG_I] = 1'b1;
					end
					3'h5: addr_nxt = `TRAP_VEC;
					`TRAP_STEP_VHI: begin
						op1_nxt = mem_rdata;
						addr_nxt = `TRAP_VEC + 16'h0001;
					end
					default: begin
						pc_nxt = {op1_r, mem_rdata};
						addr_nxt = pc_nxt;
						state_nxt = S_FETCH;
					end
				endcase
			end
			default: state_nxt = S_FETCH;
		endcase
	end

	// Register update.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= S_FETCH;
			cnt_r <= 3'h0;
			op1_r <= 8'h00;
			rel_r <= 8'h00;
			cls_r <= `CLS_NOP;
			mode_r <= `MODE_DIR;
			nb_r <= 2'h0;
			hasrel_r <= 1'b0;
			post_r <= 1'b0;
			mov_r <= `MOV_NONE;
			mem_addr_r <= `RST_PC;
			mem_we_r <= 1'b0;
			mem_wdata_r <= 8'h00;
			halted_r <= 1'b0;
			fetch_r <= 1'b1;
			pc_r <= `RST_PC;
			sp_r <= `RST_SP;
			acc_r <= 8'h00;
			idx_hi_r <= 8'h00;
			idx_lo_r <= 8'h00;
			condition_flags_r <= `RST_FLAGS;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			op1_r <= op1_nxt;
			rel_r <= rel_nxt;
			cls_r <= cls_nxt;
			mode_r <= mode_nxt;
			nb_r <= nb_nxt;
			hasrel_r <= hasrel_nxt;
			post_r <= post_nxt;
			mov_r <= mov_nxt;
			mem_addr_r <= addr_nxt;
			mem_we_r <= we_nxt;
			mem_wdata_r <= wdata_nxt;
			halted_r <= halted_nxt;
			fetch_r <= (state_nxt == S_FETCH);
			pc_r <= pc_nxt;
			sp_r <= sp_nxt;
			acc_r <= acc_nxt;
			idx_hi_r <= xh_nxt;
			idx_lo_r <= xl_nxt;
			condition_flags_r <= flg_nxt | `FLG_ONES;
		end
	end

	// Request pin synchroniser; level changes once stages two and three agree.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_s1_r <= 1'b0;
			irq_s2_r <= 1'b0;
			irq_s3_r <= 1'b0;
			irq_lvl_r <= 1'b0;
		end else begin
			irq_s1_r <= irq_req;
			irq_s2_r <= irq_s1_r;
			irq_s3_r <= irq_s2_r;
			if (irq_s2_r == irq_s3_r)
				irq_lvl_r <= irq_s3_r;
		end
	end

endmodule // cpu_insn_tail_decode

// ===== shared/cpu_insn_tail_decode_defines.vh
// Behaviour
// - The trap opcode bumps the counter, pushes counter low, counter high, index low, accumulator and flags with the stack pointer stepping down, then sets the mask, in nine cycles.
// - After stacking, the trap loads counter high then low from its vector and changes no flag but the mask.
// - The one-byte wait opcode clears the interrupt mask in one cycle and leaves the other flags alone.
// - After the wait opcode the core freezes its execution until an interrupt request arrives.
// - The zero test checks accumulator, index low or a memory byte, clears overflow, sets negative and zero, keeps carry, in 3, 1, 1, 3, 2 and 4 cycles by form.
// - Short offset post increment mode addresses the index pair plus one offset byte and then increments the pair.
// - Plain index post increment mode addresses the index pair directly and then increments it.
// - Direct to index move reads a direct byte, writes it at the index pair and increments the pair.
// - Index to direct move reads at the index pair, increments the pair and writes to a direct address.
// - Immediate to direct move writes an instruction byte to a direct address from the instruction.
// - Stack short offset mode adds one unsigned offset byte to the stack pointer.
// - Stack long offset mode adds a two-byte instruction offset to the stack pointer.
// - Full address mode fetches the high address byte first, then the low byte.
// - Index long offset mode fetches high then low offset bytes and adds them to the index pair.
// - Direct compare and branch fetches a direct address byte and then a signed branch offset byte.
`ifndef CPU_INSN_TAIL_DECODE_DEFINES_VH
`define CPU_INSN_TAIL_DECODE_DEFINES_VH

// Opcodes; prefixed forms list the byte after the prefix.
`define OP_PREFIX 8'h9E
`define OP_TRAP 8'h83
`define OP_TAP 8'h84
`define OP_FLAGS_TO_ACC 8'h85
`define OP_WAIT 8'h8F
`define OP_INDEX_TO_STACK 8'h94
`define OP_STACK_TO_INDEX 8'h95
`define OP_ACC_TO_INDEX 8'h97
`define OP_INDEX_TO_ACC 8'h9F
`define OP_ZT_DIR 8'h3D
`define OP_ZT_A 8'h4D
`define OP_ZT_X 8'h5D
`define OP_ZT_IX1 8'h6D
`define OP_ZT_IX 8'h7D
`define OP_ZT_SPS 8'h6D
`define OP_CBEQ_DIR 8'h31
`define OP_CBEQ_IX1P 8'h61
`define OP_CBEQ_IXP 8'h71
`define OP_CBEQ_SPS 8'h61
`define OP_MOV_DIXP 8'h5E
`define OP_MOV_IMMD 8'h6E
`define OP_MOV_IXPD 8'h7E
`define OP_LDA_FULL 8'hC6
`define OP_LDA_IXL 8'hD6
`define OP_LDA_SPL 8'hD6

// Flag bit positions; bits 6 and 5 always read as one.
`define FLG_V 7
`define FLG_H 4
`define FLG_I 3
`define FLG_N 2
`define FLG_Z 1
`define FLG_C 0
`define FLG_ONES 8'h60

// Reset values and trap vector.
`define RST_PC 16'h0000
`define RST_SP 16'h00FF
`define RST_FLAGS 8'h68
`define TRAP_VEC 16'hFFFC

// Addressing modes.
`define MODE_DIR 3'h0
`define MODE_IX 3'h1
`define MODE_IX1 3'h2
`define MODE_IXL 3'h3
`define MODE_SPS 3'h4
`define MODE_SPL 3'h5
`define MODE_FULL 3'h6

// Move kinds.
`define MOV_NONE 2'h0
`define MOV_DIXP 2'h1
`define MOV_IMMD 2'h2
`define MOV_IXPD 2'h3

// Instruction classes.
`define CLS_NOP 4'h0
`define CLS_A2X 4'h1
`define CLS_X2A 4'h2
`define CLS_F2A 4'h3
`define CLS_TAP 4'h4
`define CLS_S2X 4'h5
`define CLS_X2S 4'h6
`define CLS_ZTA 4'h7
`define CLS_ZTX 4'h8
`define CLS_WAIT 4'h9
`define CLS_TRAP 4'hA
`define CLS_ZT 4'hB
`define CLS_LDA 4'hC
`define CLS_CBEQ 4'hD
`define CLS_MOV 4'hE

// Trap sequence step where the vector high byte is read.
`define TRAP_STEP_VHI 3'h6

`endif

// ===== src/operand_addr_gen.v
`timescale 1ns/1ps
`include "cpu_insn_tail_decode_defines.vh"
module operand_addr_gen (
	// Mode and base registers.
	input wire [2:0] mode,
	input wire [15:0] hx,
	input wire [15:0] sp,
	// Operand bytes from the instruction stream.
	input wire [7:0] hi,
	input wire [7:0] lo,
	// Effective address.
	output reg [15:0] ea
);

	// Forms the operand address for each mode.
	always @* begin
		case (mode)
			`MODE_DIR: ea = {8'h00, lo};
			`MODE_IX: ea = hx;
			`MODE_IX1: ea = hx + {8'h00, lo};
			`MODE_IXL: ea = hx + {hi, lo};
			`MODE_SPS: ea = sp + {8'h00, lo};
			`MODE_SPL: ea = sp + {hi, lo};
			`MODE_FULL: ea = {hi, lo};
			default: ea = {8'h00, lo};
		endcase
	end

endmodule // operand_addr_gen

// ===== testbench/tail_decode_chk_sva.sv
`timescale 1ns/1ps
`include "cpu_insn_tail_decode_defines.vh"
module tail_decode_chk (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Memory bus and interrupt pin.
	input wire logic [15:0] mem_addr_r,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_we_r,
	input wire logic [7:0] mem_wdata_r,
	input wire logic irq_req,
	// Core status.
	input wire logic halted_r,
	input wire logic fetch_r,
	input wire logic [15:0] pc_r,
	input wire logic [15:0] sp_r,
	input wire logic [7:0] acc_r,
	input wire logic [7:0] idx_hi_r,
	input wire logic [7:0] idx_lo_r,
	input wire logic [7:0] condition_flags_r
);
	// An opcode is issued when it is fetched outside the frozen state.
	wire [15:0] hx = {idx_hi_r, idx_lo_r};
	wire [7:0] ret_lo = mem_addr_r[7:0] + 8'h01;
	wire issue = fetch_r && !halted_r;
	wire [7:0] op = mem_rdata;
	wire [7:0] fl = condition_flags_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	trap_push_a: assert property (issue && op == `OP_TRAP |=>
		mem_we_r && mem_addr_r == $past(sp_r) && mem_wdata_r == $past(ret_lo)
		##1 mem_we_r [*4] ##1 !mem_we_r && fl[`FLG_I])
		else $error("trap stacking sequence wrong");
	trap_vec_a: assert property (issue && op == `OP_TRAP |->
		##7 mem_addr_r == `TRAP_VEC ##1 mem_addr_r == `TRAP_VEC + 16'h0001
		##1 fetch_r && mem_addr_r == {$past(mem_rdata, 2), $past(mem_rdata)}
		&& (fl & 8'hF7) == ($past(fl, 9) & 8'hF7))
		else $error("trap vector load wrong");
	wait_mask_a: assert property (issue && op == `OP_WAIT |=>
		halted_r && !fl[`FLG_I] && (fl & 8'hF7) == ($past(fl) & 8'hF7))
		else $error("wait did not clear mask and halt");
	halt_freeze_a: assert property (halted_r && $past(halted_r) |->
		$stable(mem_addr_r) && !mem_we_r && $stable(acc_r) && $stable(sp_r))
		else $error("core moved while halted");
	halt_stay_a: assert property ((!irq_req) [*4] ##0 halted_r |=>
		halted_r) else $error("woke without request");
	halt_wake_a: assert property ($rose(irq_req) && halted_r |->
		##[1:8] !halted_r) else $error("request did not wake core");
	zero_test_a: assert property (issue && op == `OP_ZT_A |=>
		fetch_r && !fl[`FLG_V] && fl[`FLG_N] == $past(acc_r[7])
		&& fl[`FLG_Z] == ($past(acc_r) == 8'h00)
		&& fl[`FLG_C] == $past(fl[`FLG_C])) else $error("zero test wrong");
	stack_index_a: assert property (issue && op == `OP_STACK_TO_INDEX |->
		##2 fetch_r && hx == $past(sp_r, 2) + 16'h0001 && fl == $past(fl, 2))
		else $error("stack to index wrong");
	index_stack_a: assert property (issue && op == `OP_INDEX_TO_STACK |->
		##2 fetch_r && sp_r == $past(hx, 2) - 16'h0001)
		else $error("index to stack wrong");
	acc_flags_a: assert property (issue && op == `OP_TAP |->
		##2 fetch_r && fl == ($past(acc_r, 2) | `FLG_ONES))
		else $error("accumulator to flags wrong");
endmodule // tail_decode_chk

bind cpu_insn_tail_decode tail_decode_chk chk (.clk(clk), .rst_n(rst_n),
	.mem_addr_r(mem_addr_r), .mem_rdata(mem_rdata), .mem_we_r(mem_we_r),
	.mem_wdata_r(mem_wdata_r), .irq_req(irq_req), .halted_r(halted_r),
	.fetch_r(fetch_r), .pc_r(pc_r), .sp_r(sp_r), .acc_r(acc_r),
	.idx_hi_r(idx_hi_r), .idx_lo_r(idx_lo_r),
	.condition_flags_r(condition_flags_r));

// ===== testbench/mem_model.sv
`timescale 1ns/1ps
module mem_model (
	// Clock.
	input wire logic clk,
	// Core bus.
	input wire logic [15:0] addr,
	output wire logic [7:0] rdata,
	input wire logic we,
	input wire logic [7:0] wdata
);
	logic [7:0] m [0:65535];
	// Unused locations hold a harmless one-cycle opcode.
	initial for (int i = 0; i < 65536; i++) m[i] = 8'h9D;
	// Reads follow the shown address with no wait state.
	assign rdata = m[addr];
	// Writes land on the edge that ends the strobe cycle.
	always @(posedge clk) begin
		if (we) m[addr] <= wdata;
	end
endmodule // mem_model

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`include "cpu_insn_tail_decode_defines.vh"
module tb_top;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg irq_req = 1'b0;
	wire [15:0] mem_addr_r, pc_r, sp_r;
	wire [7:0] mem_rdata, mem_wdata_r, acc_r, idx_hi_r, idx_lo_r, fl;
	wire mem_we_r, halted_r, fetch_r;
	integer n_mismatch = 0;
	integer checks = 0;

	// Core under test and the memory it runs from.
	cpu_insn_tail_decode DUT (.clk(clk), .rst_n(rst_n),
		.mem_addr_r(mem_addr_r), .mem_rdata(mem_rdata), .mem_we_r(mem_we_r),
		.mem_wdata_r(mem_wdata_r), .irq_req(irq_req), .halted_r(halted_r),
		.fetch_r(fetch_r), .pc_r(pc_r), .sp_r(sp_r), .acc_r(acc_r),
		.idx_hi_r(idx_hi_r), .idx_lo_r(idx_lo_r), .condition_flags_r(fl));
	mem_model mem (.clk(clk), .addr(mem_addr_r), .rdata(mem_rdata),
		.we(mem_we_r), .wdata(mem_wdata_r));

	// Clock of 4 ns period.
	always #2 clk = ~clk;

	task check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task give_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Runs to the next opcode fetch, checking its address and, when cyc is positive, its cycle count.
	task step(input logic [15:0] at, input integer cyc);
		integer n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n = n + 1;
		end while (!fetch_r && n < 40);
		check("fetch address", mem_addr_r, at);
		if (cyc > 0) check("cycles", n[15:0], cyc[15:0]);
	endtask

	task load(input logic [15:0] a, input logic [7:0] b[$]);
		foreach (b[i]) mem.m[a + i] = b[i];
	endtask

	// Full address load, then flag and register copies.
	task t_xfer;
		step(16'h0003, 4);
		check("acc", {8'h00, acc_r}, 16'h0080);
		step(16'h0004, 2);
		check("flags", {8'h00, fl}, 16'h00E0);
		step(16'h0005, 1);
		check("index low", {8'h00, idx_lo_r}, 16'h0080);
		step(16'h0006, 1);
		check("flags", {8'h00, fl}, 16'h0064);
	endtask

	// Software trap stacks five bytes and jumps through its vector.
	task t_trap;
		logic [7:0] stk [5];
		integer i;
		stk = '{8'h07, 8'h00, 8'h80, 8'h80, 8'h64};
		step(16'h0200, 9);
		check("program counter", pc_r, 16'h0200);
		check("stack pointer", sp_r, 16'h00FA);
		check("flags", {8'h00, fl}, 16'h006C);
		for (i = 0; i < 5; i++) begin
			check("stacked", {8'h00, mem.m[16'h00FF - i]}, {8'h00, stk[i]});
		end
	endtask

	// Stack transfers, indexed test and the three move modes.
	task t_moves;
		step(16'h0201, 2);
		check("index pair", {idx_hi_r, idx_lo_r}, 16'h00FB);
		step(16'h0202, 2);
		check("flags", {8'h00, fl}, 16'h0068);
		step(16'h0203, 2);
		check("stack pointer", sp_r, 16'h00FA);
		step(16'h0206, 0);
		check("imm move", {8'h00, mem.m[16'h0040]}, 16'h0000);
		step(16'h0208, 0);
		check("dir move", {8'h00, mem.m[16'h00FB]}, 16'h0000);
		check("index pair", {idx_hi_r, idx_lo_r}, 16'h00FC);
		step(16'h020A, 0);
		check("idx move", {8'h00, mem.m[16'h0050]}, 16'h0080);
		check("index pair", {idx_hi_r, idx_lo_r}, 16'h00FD);
		step(16'h020C, 3);
		check("flags", {8'h00, fl}, 16'h006C);
	endtask

	// Wait halts the core until a request arrives.
	task t_wait;
		integer n;
		@(posedge clk);
		#1;
		check("halted", {15'h0000, halted_r}, 16'h0001);
		check("flags", {8'h00, fl}, 16'h0064);
		repeat (20) @(posedge clk);
		#1;
		check("halted", {15'h0000, halted_r}, 16'h0001);
		check("held address", mem_addr_r, 16'h020D);
		irq_req = 1'b1;
		n = 0;
		while (halted_r && n < 20) begin
			@(posedge clk);
			#1;
			n = n + 1;
		end
		irq_req = 1'b0;
		check("halted", {15'h0000, halted_r}, 16'h0000);
	endtask

	// Stack, index and branch operand forms after wake-up.
	task t_modes;
		if (!fetch_r) step(16'h020D, 0);
		step(16'h0210, 4);
		check("flags", {8'h00, fl}, 16'h0062);
		step(16'h0214, 5);
		check("acc", {8'h00, acc_r}, 16'h0080);
		step(16'h0217, 4);
		check("acc", {8'h00, acc_r}, 16'h005A);
		step(16'h021E, 4);
		step(16'h021F, 1);
		check("acc", {8'h00, acc_r}, 16'h00FD);
		step(16'h0221, 3);
		check("index pair", {idx_hi_r, idx_lo_r}, 16'h00FE);
		step(16'h0224, 4);
		check("index pair", {idx_hi_r, idx_lo_r}, 16'h00FF);
	endtask

	// Program load, reset and the scenario sequence.
	initial begin
		#1;
		load(16'h0000, '{8'hC6, 8'h01, 8'h00, 8'h84, 8'h97, 8'h4D, 8'h83});
		load(16'h0100, '{8'h80});
		load(16'h0060, '{8'h5A});
		load(16'h01FD, '{8'h5A});
		load(16'hFFFC, '{8'h02, 8'h00});
		load(16'h0200, '{8'h95, 8'h7D, 8'h94, 8'h6E, 8'h00, 8'h40, 8'h5E,
			8'h40, 8'h7E, 8'h50, 8'h3D, 8'h50, 8'h8F, 8'h9E, 8'h6D, 8'h01});
		load(16'h0210, '{8'h9E, 8'hD6, 8'h00, 8'h03, 8'hD6, 8'h01, 8'h00,
			8'h31, 8'h60, 8'h04});
		load(16'h021E, '{8'h9F, 8'h71, 8'h00, 8'h61, 8'h01, 8'h00});
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		t_xfer;
		t_trap;
		t_moves;
		t_wait;
		t_modes;
		give_verdict;
	end

	// Watchdog well beyond the hundred or so cycles the run needs.
	initial begin
		#(4 * 2000);
		n_mismatch = n_mismatch + 1;
		give_verdict;
	end
endmodule // tb_top
